//--- rtl/osc_clock_regs.svh
`ifndef OSC_CLOCK_REGS_SVH
`define OSC_CLOCK_REGS_SVH

// Register word offsets (byte addresses)
`define OSC_CTRL_OFFSET 8'h00
`define CLK_CFG_OFFSET 8'h04

// Oscillator control fields
`define OC_FI_ENABLE_BIT 0
`define OC_FI_READY_BIT 1
`define OC_TRIM_LSB 3
`define OC_CAL_LSB 8
`define OC_FE_ENABLE_BIT 16
`define OC_FE_READY_BIT 17
`define OC_MONITOR_BIT 19
`define OC_PLL_ENABLE_BIT 24
`define OC_PLL_READY_BIT 25

// Clock configuration fields
`define CC_ROOT_SEL_LSB 0
`define CC_ROOT_STAT_LSB 2
`define CC_AHB_LSB 4
`define CC_APB1_LSB 8
`define CC_APB2_LSB 11
`define CC_PLL_SRC_BIT 16
`define CC_PLL_HALF_BIT 17
`define CC_PLL_MUL_LSB 18
`define CC_I2S_BIT 23
`define CC_OUT_SEL_LSB 24
`define CC_OUT_DIV_LSB 28
`define CC_PLL_UNDIV_BIT 31

// Reset values
`define CLK_CFG_RESET 32'h0000_0000
`define TRIM_RESET 5'h10

// Timing counts
`define READY_FALL_CYCLES 3'h6
`define SWITCH_WAIT_CYCLES 2'h2

`endif

//--- rtl/osc_clock_pkg.sv
package osc_clock_pkg;

typedef enum logic [1:0] {
    ROOT_INTERNAL = 2'b00,
    ROOT_EXTERNAL = 2'b01,
    ROOT_PLL = 2'b10,
    ROOT_FORBIDDEN = 2'b11
} root_e;

typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_BUSY = 2'b01,
    SW_DONE = 2'b10
} switch_e;

typedef logic [2:0] osc_count_t;

endpackage

//--- rtl/osc_clock_ctrl.sv
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "osc_clock_regs.svh"

// Overview of operation
// - External ready sets when stable, falls six cycles
// - Low-power entry clears external enable
// - External enable clear ignored while feeding root
// - Factory calibration loaded at startup, read-only
// - Trim added to calibration, resets to 16
// - Internal ready sets when stable, falls six cycles
// - Internal enable forced on wake or failure
// - Internal enable clear refused while used or selected
// - Zero waits, two during switch
// - Undivided bit picks PLL or PLL halved
// - Output divided by two to code power
// - Three-bit output source select, 000 off
// - I2S clock from root or external pin
// - Multiplier code plus two, 1111 gives 16, written only PLL off
// - External halving bit, written only PLL off
// - PLL input select, written only PLL off
// - APB2 divider from AHB, 0xx undivided
// - APB1 divider from AHB, same encoding
// - AHB divider from root, up to 512
// - Status field reports active root
// - Root select cleared on wake or failure
// - Monitor active when external ready, off on failure
// - PLL enable cleared on low-power, clear guarded
module osc_clock_ctrl #(
    parameter logic [7:0] FACTORY_CAL = 8'h80,
    parameter int SWITCH_CYCLES = 2
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic fast_external_stable,
    input wire logic fast_internal_stable,
    input wire logic fast_external_osc_tick,
    input wire logic fast_internal_osc_tick,
    input wire logic pll_locked,
    input wire logic low_power_entry,
    input wire logic low_power_exit,
    input wire logic external_clock_fail,
    output logic fast_external_enable,
    output logic fast_internal_enable,
    output logic pll_enable,
    output logic fast_external_ready,
    output logic fast_internal_ready,
    output logic monitor_active,
    output logic [1:0] core_root_clock,
    output logic [4:0] fast_internal_trim_sum,
    output logic [8:0] fast_internal_freq_code,
    output logic pll_input_select,
    output logic pll_external_halving,
    output logic [4:0] pll_factor,
    output logic [9:0] ahb_div_ratio,
    output logic [4:0] apb1_div_ratio,
    output logic [4:0] apb2_div_ratio,
    output logic [2:0] clock_output_select,
    output logic [7:0] clock_output_div_ratio,
    output logic pll_output_undivided,
    output logic i2s_clock_select
);

// ==========================================================
// Helpers
function automatic logic [4:0] apb_ratio(input logic [2:0] code);
    apb_ratio = code[2] ? (5'h02 << code[1:0]) : 5'h01;
endfunction

function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                      input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
        if (be[i]) begin
            merge[i*8 +: 8] = wd[i*8 +: 8];
        end
    end
endfunction

// ==========================================================
// Register state
logic fi_en_ff, fe_en_ff, pll_en_ff, mon_en_ff, mon_act_ff;
logic fi_rdy_ff, fe_rdy_ff;
logic [2:0] fi_fall_ff, fe_fall_ff;
logic [4:0] trim_ff;
logic [7:0] cal_ff;
logic cal_loaded_ff;
logic [31:0] cfg_ff;
logic [1:0] stat_ff;
osc_clock_pkg::switch_e sw_state_ff;
logic [1:0] sw_cnt_ff;
logic [1:0] pend_root_ff;
logic [1:0] wait_ff;

logic wr_ctrl, wr_cfg, pll_busy;
logic [31:0] ctrl_word, ctrl_new, cfg_new;
logic [1:0] sel;
logic fail, fe_root, fi_root, pll_root;

assign sel = cfg_ff[`CC_ROOT_SEL_LSB +: 2];
assign fail = external_clock_fail && mon_act_ff && fe_root;
assign pll_busy = pll_en_ff;

assign ctrl_word = {6'h00, pll_locked, pll_en_ff, 4'h0, mon_en_ff, 1'b0, fe_rdy_ff, fe_en_ff,
                    cal_ff, trim_ff, 1'b0, fi_rdy_ff, fi_en_ff};

// ==========================================================
// Bus slave
logic busy_switch;
assign busy_switch = (sw_state_ff == osc_clock_pkg::SW_BUSY);

always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
        wait_ff <= 2'h0;
    end else if ((avs_read || avs_write) && avs_address == `CLK_CFG_OFFSET && busy_switch
                 && wait_ff == 2'h0) begin
        wait_ff <= `SWITCH_WAIT_CYCLES;
    end else if (wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
    end
end

// Zero waits, stretched during a root switch
assign avs_waitrequest = ((avs_read || avs_write) && avs_address == `CLK_CFG_OFFSET
                          && (busy_switch && wait_ff == 2'h0 || wait_ff == 2'h2));

logic accept;
assign accept = (avs_read || avs_write) && !avs_waitrequest;
assign wr_ctrl = avs_write && accept && avs_address == `OSC_CTRL_OFFSET;
assign wr_cfg = avs_write && accept && avs_address == `CLK_CFG_OFFSET;
assign ctrl_new = merge(ctrl_word, avs_writedata, avs_byteenable);
assign cfg_new = merge(cfg_ff, avs_writedata, avs_byteenable);

// Read data stands in the accepting cycle, muxed straight from registers
always_comb begin
    case (avs_address)
        `OSC_CTRL_OFFSET: avs_readdata = ctrl_word;
        `CLK_CFG_OFFSET: avs_readdata = {cfg_ff[31:4], stat_ff, cfg_ff[1:0]};
        default: avs_readdata = 32'h0;
    endcase
end

// ==========================================================
// Oscillator enables
assign fe_root = stat_ff == osc_clock_pkg::ROOT_EXTERNAL
                 || (stat_ff == osc_clock_pkg::ROOT_PLL && cfg_ff[`CC_PLL_SRC_BIT]);
assign fi_root = stat_ff == osc_clock_pkg::ROOT_INTERNAL || sel == osc_clock_pkg::ROOT_INTERNAL
                 || (stat_ff == osc_clock_pkg::ROOT_PLL && !cfg_ff[`CC_PLL_SRC_BIT]);
assign pll_root = stat_ff == osc_clock_pkg::ROOT_PLL || sel == osc_clock_pkg::ROOT_PLL;

always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
        fe_en_ff <= 1'b0;
    end else if (low_power_entry) begin
        fe_en_ff <= 1'b0;
    end else if (wr_ctrl) begin
        fe_en_ff <= ctrl_new[`OC_FE_ENABLE_BIT] || (fe_en_ff && fe_root);
    end
end

always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
        fi_en_ff <= 1'b1;
    end else if (low_power_exit || fail) begin
        fi_en_ff <= 1'b1;
    end else if (wr_ctrl) begin
        fi_en_ff <= ctrl_new[`OC_FI_ENABLE_BIT] || (fi_en_ff && fi_root);
    end
end

always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
        pll_en_ff <= 1'b0;
    end else if (low_power_entry) begin
        pll_en_ff <= 1'b0;
    end else if (wr_ctrl) begin
        pll_en_ff <= ctrl_new[`OC_PLL_ENABLE_BIT] || (pll_en_ff && pll_root);
    end
end

always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
        mon_en_ff <= 1'b0;
    end else if (wr_ctrl) begin
        mon_en_ff <= ctrl_new[`OC_MONITOR_BIT];
    end
end

always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
        mon_act_ff <= 1'b0;
    end else if (mon_act_ff && external_clock_fail) begin
        mon_act_ff <= 1'b0;
    end else begin
        mon_act_ff <= mon_en_ff && fe_rdy_ff;
    end
end

always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
        trim_ff <= `TRIM_RESET;
    end else if (wr_ctrl) begin
        trim_ff <= ctrl_new[`OC_TRIM_LSB +: 5];
    end
end

// Calibration captured after reset release
always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
        cal_ff <= 8'h00;
        cal_loaded_ff <= 1'b0;
    end else if (!cal_loaded_ff) begin
        cal_ff <= FACTORY_CAL;
        cal_loaded_ff <= 1'b1;
    end
end

// ==========================================================
// Ready flags, falling six oscillator cycles after disable
always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
        fe_rdy_ff <= 1'b0;
        fe_fall_ff <= 3'h0;
    end else if (fe_en_ff) begin
        fe_fall_ff <= 3'h0;
        if (fast_external_stable) begin
            fe_rdy_ff <= 1'b1;
        end
    end else if (fe_rdy_ff && fast_external_osc_tick) begin
        if (fe_fall_ff == `READY_FALL_CYCLES - 3'h1) begin
            fe_rdy_ff <= 1'b0;
        end
        fe_fall_ff <= fe_fall_ff + 3'h1;
    end
end

always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
        fi_rdy_ff <= 1'b0;
        fi_fall_ff <= 3'h0;
    end else if (fi_en_ff) begin
        fi_fall_ff <= 3'h0;
        if (fast_internal_stable) begin
            fi_rdy_ff <= 1'b1;
        end
    end else if (fi_rdy_ff && fast_internal_osc_tick) begin
        if (fi_fall_ff == `READY_FALL_CYCLES - 3'h1) begin
            fi_rdy_ff <= 1'b0;
        end
        fi_fall_ff <= fi_fall_ff + 3'h1;
    end
end

// ==========================================================
// Clock configuration register
logic [31:0] nxt_cfg;
always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_cfg) begin
        nxt_cfg[31:23] = cfg_new[31:23];
        nxt_cfg[27] = 1'b0;
        nxt_cfg[15:4] = {2'b00, cfg_new[13:4]};
        if (!pll_busy) begin
            nxt_cfg[21:16] = cfg_new[21:16];
        end
        if (cfg_new[1:0] != osc_clock_pkg::ROOT_FORBIDDEN) begin
            nxt_cfg[1:0] = cfg_new[1:0];
        end
    end
    if (low_power_exit || fail) begin
        nxt_cfg[1:0] = osc_clock_pkg::ROOT_INTERNAL;
    end
end

always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
        cfg_ff <= `CLK_CFG_RESET;
    end else begin
        cfg_ff <= nxt_cfg;
    end
end

// ==========================================================
// Root switch sequencing
always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
        sw_state_ff <= osc_clock_pkg::SW_IDLE;
        sw_cnt_ff <= 2'h0;
        pend_root_ff <= 2'h0;
        stat_ff <= 2'h0;
    end else begin
        case (sw_state_ff)
            osc_clock_pkg::SW_IDLE: begin
                if (sel != stat_ff) begin
                    pend_root_ff <= sel;
                    sw_cnt_ff <= 2'(SWITCH_CYCLES - 1);
                    sw_state_ff <= osc_clock_pkg::SW_BUSY;
                end
            end
            osc_clock_pkg::SW_BUSY: begin
                if (sw_cnt_ff == 2'h0) begin
                    sw_state_ff <= osc_clock_pkg::SW_DONE;
                end else begin
                    sw_cnt_ff <= sw_cnt_ff - 2'h1;
                end
            end
            osc_clock_pkg::SW_DONE: begin
                stat_ff <= pend_root_ff;
                sw_state_ff <= osc_clock_pkg::SW_IDLE;
            end
            default: sw_state_ff <= osc_clock_pkg::SW_IDLE;
        endcase
    end
end

// ==========================================================
// Outputs
always_comb begin
    fast_external_enable = fe_en_ff;
    fast_internal_enable = fi_en_ff;
    pll_enable = pll_en_ff;
    fast_external_ready = fe_rdy_ff;
    fast_internal_ready = fi_rdy_ff;
    monitor_active = mon_act_ff;
    core_root_clock = stat_ff;
    fast_internal_trim_sum = trim_ff;
    fast_internal_freq_code = {1'b0, cal_ff} + {4'h0, trim_ff};
    pll_input_select = cfg_ff[`CC_PLL_SRC_BIT];
    pll_external_halving = cfg_ff[`CC_PLL_HALF_BIT];
    pll_factor = (cfg_ff[21:18] == 4'hf) ? 5'h10 : {1'b0, cfg_ff[21:18]} + 5'h02;
    ahb_div_ratio = !cfg_ff[7] ? 10'h001 :
                    cfg_ff[6] ? (10'h040 << cfg_ff[5:4]) : (10'h002 << cfg_ff[5:4]);
    apb1_div_ratio = apb_ratio(cfg_ff[10:8]);
    apb2_div_ratio = apb_ratio(cfg_ff[13:11]);
    clock_output_select = cfg_ff[`CC_OUT_SEL_LSB +: 3];
    clock_output_div_ratio = 8'h01 << cfg_ff[`CC_OUT_DIV_LSB +: 3];
    pll_output_undivided = cfg_ff[`CC_PLL_UNDIV_BIT];
    i2s_clock_select = cfg_ff[`CC_I2S_BIT];
end

// ==========================================================
// Checks
chk_fe_lowpower: assert property (@(posedge ref_clk) disable iff (!rst_b)
    low_power_entry |=> !fast_external_enable) else $error("ext enable kept");
chk_fi_wake: assert property (@(posedge ref_clk) disable iff (!rst_b)
    low_power_exit |=> fast_internal_enable) else $error("int enable not forced");
chk_sel_wake: assert property (@(posedge ref_clk) disable iff (!rst_b)
    low_power_exit |=> cfg_ff[1:0] == 2'b00) else $error("select not cleared");
chk_sel_forbid: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cfg_ff[1:0] != 2'b11) else $error("forbidden select");
chk_stat_never3: assert property (@(posedge ref_clk) disable iff (!rst_b)
    stat_ff != 2'b11) else $error("bad status");
chk_stat_delay: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $changed(stat_ff) |-> $past(sw_state_ff) == osc_clock_pkg::SW_DONE)
    else $error("status changed early");
chk_pll_guard: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pll_busy |=> $stable(cfg_ff[21:16])) else $error("pll field moved");
chk_wait_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
    avs_waitrequest |-> ##[1:3] !avs_waitrequest) else $error("too many waits");
chk_fe_keep: assert property (@(posedge ref_clk) disable iff (!rst_b)
    fe_root && !low_power_entry && fe_en_ff |=> fe_en_ff) else $error("ext enable dropped");
chk_mul_top: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cfg_ff[21:18] == 4'he |-> pll_factor == 5'h10) else $error("mul wrong");
cov_switch: cover property (@(posedge ref_clk) disable iff (!rst_b)
    sw_state_ff == osc_clock_pkg::SW_DONE);
cov_wait: cover property (@(posedge ref_clk) disable iff (!rst_b) avs_waitrequest);
cov_fail: cover property (@(posedge ref_clk) disable iff (!rst_b) fail);

endmodule
`default_nettype wire

//--- bench/test_osc_clock_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_osc_clock_ctrl;
    localparam logic [7:0] cal_val = 8'h5a;
    // ============================================================
    // Stimulus and observed signals
    logic ref_clk = 1'h0;
    logic rst_b = 1'h0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic fast_external_stable = 1'h0;
    logic fast_internal_stable = 1'h1;
    logic fast_external_osc_tick = 1'h0;
    logic fast_internal_osc_tick = 1'h0;
    logic pll_locked = 1'h0;
    logic low_power_entry = 1'h0;
    logic low_power_exit = 1'h0;
    logic external_clock_fail = 1'h0;
    logic fast_external_enable, fast_internal_enable, pll_enable;
    logic fast_external_ready, fast_internal_ready, monitor_active;
    logic pll_input_select, pll_external_halving, pll_output_undivided, i2s_clock_select;
    logic [1:0] core_root_clock;
    logic [4:0] fast_internal_trim_sum, pll_factor, apb1_div_ratio, apb2_div_ratio;
    logic [8:0] fast_internal_freq_code;
    logic [9:0] ahb_div_ratio;
    logic [2:0] clock_output_select;
    logic [7:0] clock_output_div_ratio;
    int num_errors = 0;
    int checked = 0;
    int last_waits;
    logic [31:0] rd;
    logic [4:0] trim_now = 5'h10;

    osc_clock_ctrl #(.FACTORY_CAL(cal_val), .SWITCH_CYCLES(2)) osc_clock_ctrl_i (
        .ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .fast_external_stable,
        .fast_internal_stable, .fast_external_osc_tick, .fast_internal_osc_tick,
        .pll_locked, .low_power_entry, .low_power_exit, .external_clock_fail,
        .fast_external_enable, .fast_internal_enable, .pll_enable, .fast_external_ready,
        .fast_internal_ready, .monitor_active, .core_root_clock, .fast_internal_trim_sum,
        .fast_internal_freq_code, .pll_input_select, .pll_external_halving, .pll_factor,
        .ahb_div_ratio, .apb1_div_ratio, .apb2_div_ratio, .clock_output_select,
        .clock_output_div_ratio, .pll_output_undivided, .i2s_clock_select
    );

    always #20 ref_clk = ~ref_clk;

    // ============================================================
    // Shared helpers
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask

    // Request held until an edge that sees waitrequest low
    task bus_op(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        logic done;
        @(posedge ref_clk);
        avs_address <= addr;
        avs_writedata <= data;
        avs_write <= wr;
        avs_read <= ~wr;
        last_waits = 0;
        done = 1'h0;
        while (!done) begin
            @(negedge ref_clk);
            done = (avs_waitrequest === 1'h0);
            if (done && !wr) rd = avs_readdata;
            if (!done) last_waits++;
            @(posedge ref_clk);
        end
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(negedge ref_clk);
    endtask

    function automatic logic [31:0] ctl(input logic fe, fi, mon, pll);
        ctl = 32'h0;
        ctl[24] = pll;
        ctl[19] = mon;
        ctl[16] = fe;
        ctl[7:3] = trim_now;
        ctl[0] = fi;
    endfunction

    task set_line(input int sel, input logic v);
        case (sel)
            0: fast_external_osc_tick <= v;
            1: fast_internal_osc_tick <= v;
            2: low_power_entry <= v;
            3: low_power_exit <= v;
            default: external_clock_fail <= v;
        endcase
    endtask

    task pulse(input int sel);
        @(posedge ref_clk);
        set_line(sel, 1'h1);
        @(posedge ref_clk);
        set_line(sel, 1'h0);
    endtask

    task wait_root(input logic [1:0] r);
        for (int n = 0; n < 20 && core_root_clock !== r; n++) @(negedge ref_clk);
        check(core_root_clock, r);
    endtask

    // Ready must survive five oscillator cycles and fall after the sixth
    task ready_drop(input int sel);
        repeat (5) pulse(sel);
        @(negedge ref_clk);
        check(sel == 0 ? fast_external_ready : fast_internal_ready, 1'h1);
        pulse(sel);
        repeat (2) @(negedge ref_clk);
        check(sel == 0 ? fast_external_ready : fast_internal_ready, 1'h0);
    endtask

    // ============================================================
    // Scenarios
    task test_reset_trim();
        bus_op(1'h0, 8'h00, 32'h0);
        check(last_waits, 0);
        check({rd[15:8], rd[7:3], rd[0]}, {cal_val, 5'h10, 1'h1});
        check(fast_internal_freq_code, 9'(cal_val) + 9'h10);
        trim_now = 5'h1f;
        bus_op(1'h1, 8'h00, ctl(1'h0, 1'h1, 1'h0, 1'h0) | 32'h0000_ff00);
        bus_op(1'h0, 8'h00, 32'h0);
        check(rd[15:3], {cal_val, 5'h1f});
        check(fast_internal_freq_code, 9'(cal_val) + 9'h1f);
        @(posedge ref_clk);
        avs_byteenable <= 4'h2;
        bus_op(1'h1, 8'h00, 32'h0);
        check(fast_internal_trim_sum, 5'h1f);
        @(posedge ref_clk);
        avs_byteenable <= 4'hf;
        bus_op(1'h0, 8'h04, 32'h0);
        check(rd, 32'h0);
        bus_op(1'h0, 8'h08, 32'h0);
        check(rd, 32'h0);
    endtask

    task test_external_root();
        @(posedge ref_clk);
        fast_external_stable <= 1'h1;
        bus_op(1'h1, 8'h00, ctl(1'h1, 1'h1, 1'h1, 1'h0));
        for (int n = 0; n < 20 && fast_external_ready !== 1'h1; n++) @(negedge ref_clk);
        check(fast_external_ready, 1'h1);
        @(negedge ref_clk);
        check(monitor_active, 1'h1);
        bus_op(1'h1, 8'h04, 32'h1);
        check(core_root_clock, 2'h0);
        bus_op(1'h0, 8'h04, 32'h0);
        check(last_waits >= 1 && last_waits <= 2, 1'h1);
        wait_root(2'h1);
        bus_op(1'h0, 8'h04, 32'h0);
        check(rd[3:0], 4'h5);
        bus_op(1'h1, 8'h00, ctl(1'h0, 1'h1, 1'h1, 1'h0));
        check(fast_external_enable, 1'h1);
        bus_op(1'h1, 8'h00, ctl(1'h1, 1'h0, 1'h1, 1'h0));
        check(fast_internal_enable, 1'h0);
        ready_drop(1);
        pulse(4);
        @(negedge ref_clk);
        check({fast_internal_enable, monitor_active}, 2'h2);
        wait_root(2'h0);
        bus_op(1'h0, 8'h04, 32'h0);
        check(rd[1:0], 2'h0);
    endtask

    task test_fe_drop();
        bus_op(1'h1, 8'h00, ctl(1'h0, 1'h0, 1'h0, 1'h0));
        check({fast_external_enable, fast_internal_enable}, 2'h1);
        ready_drop(0);
    endtask

    task test_forbidden();
        bus_op(1'h1, 8'h04, 32'h3);
        repeat (6) @(negedge ref_clk);
        check(core_root_clock, 2'h0);
        bus_op(1'h0, 8'h04, 32'h0);
        check(rd[1:0], 2'h0);
    endtask

    task test_pll_lowpower();
        bus_op(1'h1, 8'h04, 32'h001f_0000);
        check({pll_factor, pll_external_halving, pll_input_select}, {5'h09, 2'h3});
        @(posedge ref_clk);
        pll_locked <= 1'h1;
        bus_op(1'h1, 8'h00, ctl(1'h1, 1'h1, 1'h0, 1'h1));
        bus_op(1'h0, 8'h00, 32'h0);
        check(rd[25:24], 2'h3);
        bus_op(1'h1, 8'h04, 32'h0);
        check({pll_factor, pll_external_halving, pll_input_select}, {5'h09, 2'h3});
        bus_op(1'h1, 8'h04, 32'h001f_0002);
        wait_root(2'h2);
        bus_op(1'h1, 8'h00, ctl(1'h0, 1'h1, 1'h0, 1'h0));
        check({pll_enable, fast_external_enable}, 2'h3);
        pulse(2);
        @(negedge ref_clk);
        check({pll_enable, fast_external_enable}, 2'h0);
        bus_op(1'h1, 8'h00, ctl(1'h0, 1'h0, 1'h0, 1'h0));
        check(fast_internal_enable, 1'h0);
        pulse(3);
        @(negedge ref_clk);
        check(fast_internal_enable, 1'h1);
        wait_root(2'h0);
        bus_op(1'h0, 8'h04, 32'h0);
        check(rd[1:0], 2'h0);
    endtask

    task test_field_table();
        logic [31:0] w;
        logic [3:0] k;
        logic [2:0] c;
        logic [2:0] d;
        for (int i = 0; i < 16; i++) begin
            k = 4'(i);
            c = k[2:0];
            d = ~c;
            w = {k[0], c, 1'h0, c, k[0], 1'h0, k, k[1], k[0], 2'h0, c, d, k, 4'h0};
            bus_op(1'h1, 8'h04, w);
            bus_op(1'h0, 8'h04, 32'h0);
            check(rd, w);
            check(ahb_div_ratio, !k[3] ? 10'h1 : k[2] ? 10'h40 << k[1:0] : 10'h2 << k[1:0]);
            check(apb2_div_ratio, c[2] ? 5'h2 << c[1:0] : 5'h1);
            check(apb1_div_ratio, d[2] ? 5'h2 << d[1:0] : 5'h1);
            check(clock_output_div_ratio, 8'h1 << c);
            check(clock_output_select, c);
            check({pll_output_undivided, i2s_clock_select}, {k[0], k[0]});
            check(pll_factor, k >= 4'he ? 5'h10 : 5'(k) + 5'h2);
            check({pll_external_halving, pll_input_select}, k[1:0]);
        end
    endtask

    // ============================================================
    // Sequence, watchdog and verdict
    task conclude();
        $display("errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'h1;
        test_reset_trim();
        test_external_root();
        test_fe_drop();
        test_forbidden();
        test_pll_lowpower();
        test_field_table();
        conclude();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
